/* File: design/cgp_pkg.sv */
package cgp_pkg;

	// ***************************************************************
	// register map (byte addresses, one word each)
	// ***************************************************************
	localparam logic [7:0] CLK_CTRL_ADDR = 8'h00;
	localparam logic [7:0] PLL_CTRL_ADDR = 8'h04;
	localparam logic [7:0] CPU_DIV_ADDR = 8'h08;
	localparam logic [7:0] MODE_CTRL_ADDR = 8'h0c;
	localparam logic [7:0] PRESCALER_ADDR = 8'h10;
	localparam logic [7:0] PROTECT_ADDR = 8'h14;
	localparam logic [7:0] STATUS_ADDR = 8'h18;

	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int CLK_OUT_PIN_SEL_POS = 0;
	localparam int PERIPH_STOP_POS = 2;
	localparam int SUB_OSC_EN_POS = 4;
	localparam int MAIN_OSC_STOP_POS = 5;
	localparam int SUB_CPU_SEL_POS = 7;
	localparam int PLL_SRC_SEL_POS = 8;
	localparam int OSC_SRC_SEL_POS = 9;
	localparam int PLL_MULT_POS = 0;
	localparam int PLL_RUN_POS = 7;
	localparam int ALE_PIN_SEL_POS = 0;
	localparam int BUSCLK_DIS_POS = 2;
	localparam int FRAC_SRC_POS = 3;
	localparam int WDT_OSC_SEL_POS = 5;
	localparam int CLOCK_UNLOCK_POS = 0;
	localparam int MODE_UNLOCK_POS = 1;
	localparam int STATUS_WAIT_POS = 3;
	localparam int STATUS_STOP_POS = 4;

	// ***************************************************************
	// reset values and encodings
	// ***************************************************************
	localparam logic [4:0] CPU_DIV_RESET = 5'h08;
	localparam logic [4:0] CPU_DIV_NONE = 5'h12;
	localparam logic [4:0] CPU_DIV_16 = 5'h10;
	localparam logic [1:0] FRAC_SRC_PERIPH = 2'h0;
	localparam logic [1:0] FRAC_SRC_XIN = 2'h1;
	localparam logic [1:0] FRAC_SRC_OSC = 2'h2;
	localparam logic [1:0] CLK_OUT_PIN_PORT = 2'h0;
	localparam logic [1:0] CLK_OUT_PIN_SUB = 2'h1;
	localparam logic [1:0] CLK_OUT_PIN_DIV8 = 2'h2;
	localparam logic [1:0] CLK_OUT_PIN_DIV32 = 2'h3;
	localparam logic [1:0] ALE_BUSCLK = 2'h0;
	localparam logic [1:0] ALE_ALE = 2'h1;
	// pll factor in thirds: x2, x3, x8/3, x4
	localparam logic [3:0] PLL_NUM_X2 = 4'h6;
	localparam logic [3:0] PLL_NUM_X3 = 4'h9;
	localparam logic [3:0] PLL_NUM_X8_3 = 4'h8;
	localparam logic [3:0] PLL_NUM_X4 = 4'hc;
	localparam logic [3:0] PERIPH_DIV8_LAST = 4'h7;
	localparam logic [4:0] PERIPH_DIV32_LAST = 5'h1f;

	typedef enum logic [2:0] {
		CGP_MAIN = 3'b000,
		CGP_PLL = 3'b001,
		CGP_LOW_SPEED = 3'b010,
		CGP_LOW_POWER = 3'b011,
		CGP_OSC = 3'b100,
		CGP_OSC_LOW_POWER = 3'b101
	} cgp_mode_type;

	typedef struct packed {
		logic main_tick;
		logic xin_tick;
		logic sub_tick;
		logic osc_tick;
	} cgp_src_type;

	typedef struct packed {
		logic pll_clk;
		logic cpu_clk;
		logic bus_clk;
		logic wdt_clk;
		logic periph_div1;
		logic periph_div8;
		logic periph_div32;
		logic adc_clk;
		logic even_div_clk;
		logic sub_div32_clk;
	} cgp_clk_type;

endpackage

/* File: design/cgp_clock_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module cgp_clock_gen #(
	parameter int PERIOD_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire cgp_pkg::cgp_src_type src_in,
	input wire logic micro_mode,
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire logic ale_in,
	output cgp_pkg::cgp_clk_type clk_out,
	output logic clk_out_pin,
	output logic bus_clk_pin
);

	if (PERIOD_W < 4 || PERIOD_W > 24) begin : g_bad_width
		$error("PERIOD_W must lie between 4 and 24");
	end

	// ***************************************************************
	// software registers
	// ***************************************************************
	logic [1:0] clk_out_pin_sel_reg;
	logic periph_stop_in_wait_reg;
	logic sub_osc_enable_reg;
	logic main_osc_stop_reg;
	logic sub_cpu_sel_reg;
	logic pll_src_sel_reg;
	logic osc_src_sel_reg;
	logic [1:0] pll_mult_reg;
	logic pll_run_reg;
	logic [4:0] cpu_div_sel_reg;
	logic [1:0] ale_pin_sel_reg;
	logic busclk_out_disable_reg;
	logic [1:0] frac_src_sel_reg;
	logic wdt_osc_sel_reg;
	logic [3:0] frac_div_count_reg;
	logic clock_reg_unlock_reg;
	logic mode_reg_unlock_reg;
	logic stop_prev_reg;
	cgp_pkg::cgp_mode_type mode_reg;
	cgp_pkg::cgp_mode_type mode_next;

	logic wr_en;
	logic rd_setup;
	logic low_power_entry;
	logic stop_entry;
	logic [31:0] rdata_next;
	logic addr_ok;

	assign wr_en = psel && penable && pwrite && pready;
	assign rd_setup = psel && !penable;

	// ***************************************************************
	// operating mode
	// ***************************************************************
	always_comb begin
		if (sub_cpu_sel_reg) begin
			mode_next = main_osc_stop_reg ? cgp_pkg::CGP_LOW_POWER :
				cgp_pkg::CGP_LOW_SPEED;
		end else if (osc_src_sel_reg) begin
			mode_next = main_osc_stop_reg ? cgp_pkg::CGP_OSC_LOW_POWER :
				cgp_pkg::CGP_OSC;
		end else if (pll_src_sel_reg && pll_run_reg) begin
			mode_next = cgp_pkg::CGP_PLL;
		end else begin
			mode_next = cgp_pkg::CGP_MAIN;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= cgp_pkg::CGP_MAIN;
			stop_prev_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			stop_prev_reg <= stop_mode;
		end
	end

	assign low_power_entry = (mode_next == cgp_pkg::CGP_LOW_POWER) &&
		(mode_reg != cgp_pkg::CGP_LOW_POWER);
	assign stop_entry = stop_mode && !stop_prev_reg;

	// ***************************************************************
	// register writes
	// ***************************************************************
	// unlock bits are kept by software; a locked register ignores writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_reg_unlock_reg <= 1'b0;
			mode_reg_unlock_reg <= 1'b0;
		end else if (wr_en && paddr == cgp_pkg::PROTECT_ADDR) begin
			clock_reg_unlock_reg <= pwdata[cgp_pkg::CLOCK_UNLOCK_POS];
			mode_reg_unlock_reg <= pwdata[cgp_pkg::MODE_UNLOCK_POS];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_out_pin_sel_reg <= 2'h0;
			periph_stop_in_wait_reg <= 1'b0;
			sub_osc_enable_reg <= 1'b0;
			main_osc_stop_reg <= 1'b0;
			sub_cpu_sel_reg <= 1'b0;
			pll_src_sel_reg <= 1'b0;
			osc_src_sel_reg <= 1'b0;
			pll_mult_reg <= 2'h0;
			pll_run_reg <= 1'b0;
		end else if (wr_en && clock_reg_unlock_reg) begin
			if (paddr == cgp_pkg::CLK_CTRL_ADDR) begin
				clk_out_pin_sel_reg <= pwdata[cgp_pkg::CLK_OUT_PIN_SEL_POS +: 2];
				periph_stop_in_wait_reg <= pwdata[cgp_pkg::PERIPH_STOP_POS];
				sub_osc_enable_reg <= pwdata[cgp_pkg::SUB_OSC_EN_POS];
				main_osc_stop_reg <= pwdata[cgp_pkg::MAIN_OSC_STOP_POS];
				sub_cpu_sel_reg <= pwdata[cgp_pkg::SUB_CPU_SEL_POS];
				pll_src_sel_reg <= pwdata[cgp_pkg::PLL_SRC_SEL_POS];
				osc_src_sel_reg <= pwdata[cgp_pkg::OSC_SRC_SEL_POS];
			end
			if (paddr == cgp_pkg::PLL_CTRL_ADDR) begin
				pll_mult_reg <= pwdata[cgp_pkg::PLL_MULT_POS +: 2];
				pll_run_reg <= pwdata[cgp_pkg::PLL_RUN_POS];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ale_pin_sel_reg <= 2'h0;
			busclk_out_disable_reg <= 1'b0;
			frac_src_sel_reg <= 2'h0;
			wdt_osc_sel_reg <= 1'b0;
		end else if (wr_en && mode_reg_unlock_reg &&
			paddr == cgp_pkg::MODE_CTRL_ADDR) begin
			ale_pin_sel_reg <= pwdata[cgp_pkg::ALE_PIN_SEL_POS +: 2];
			busclk_out_disable_reg <= pwdata[cgp_pkg::BUSCLK_DIS_POS];
			frac_src_sel_reg <= pwdata[cgp_pkg::FRAC_SRC_POS +: 2];
			wdt_osc_sel_reg <= pwdata[cgp_pkg::WDT_OSC_SEL_POS];
		end
	end

	// hardware force wins over a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_div_sel_reg <= cgp_pkg::CPU_DIV_RESET;
		end else if (low_power_entry || stop_entry) begin
			cpu_div_sel_reg <= cgp_pkg::CPU_DIV_RESET;
		end else if (wr_en && paddr == cgp_pkg::CPU_DIV_ADDR) begin
			cpu_div_sel_reg <= pwdata[4:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frac_div_count_reg <= 4'h0;
		end else if (wr_en && paddr == cgp_pkg::PRESCALER_ADDR) begin
			frac_div_count_reg <= pwdata[3:0];
		end
	end

	// ***************************************************************
	// register reads and bus answer
	// ***************************************************************
	always_comb begin
		rdata_next = 32'h0;
		addr_ok = 1'b1;
		case (paddr)
		cgp_pkg::CLK_CTRL_ADDR: begin
			rdata_next[cgp_pkg::CLK_OUT_PIN_SEL_POS +: 2] = clk_out_pin_sel_reg;
			rdata_next[cgp_pkg::PERIPH_STOP_POS] = periph_stop_in_wait_reg;
			rdata_next[cgp_pkg::SUB_OSC_EN_POS] = sub_osc_enable_reg;
			rdata_next[cgp_pkg::MAIN_OSC_STOP_POS] = main_osc_stop_reg;
			rdata_next[cgp_pkg::SUB_CPU_SEL_POS] = sub_cpu_sel_reg;
			rdata_next[cgp_pkg::PLL_SRC_SEL_POS] = pll_src_sel_reg;
			rdata_next[cgp_pkg::OSC_SRC_SEL_POS] = osc_src_sel_reg;
		end
		cgp_pkg::PLL_CTRL_ADDR: begin
			rdata_next[cgp_pkg::PLL_MULT_POS +: 2] = pll_mult_reg;
			rdata_next[cgp_pkg::PLL_RUN_POS] = pll_run_reg;
		end
		cgp_pkg::CPU_DIV_ADDR: begin
			rdata_next[4:0] = cpu_div_sel_reg;
		end
		cgp_pkg::MODE_CTRL_ADDR: begin
			rdata_next[cgp_pkg::ALE_PIN_SEL_POS +: 2] = ale_pin_sel_reg;
			rdata_next[cgp_pkg::BUSCLK_DIS_POS] = busclk_out_disable_reg;
			rdata_next[cgp_pkg::FRAC_SRC_POS +: 2] = frac_src_sel_reg;
			rdata_next[cgp_pkg::WDT_OSC_SEL_POS] = wdt_osc_sel_reg;
		end
		cgp_pkg::PRESCALER_ADDR: begin
			rdata_next[3:0] = frac_div_count_reg;
		end
		cgp_pkg::PROTECT_ADDR: begin
			rdata_next[cgp_pkg::CLOCK_UNLOCK_POS] = clock_reg_unlock_reg;
			rdata_next[cgp_pkg::MODE_UNLOCK_POS] = mode_reg_unlock_reg;
		end
		cgp_pkg::STATUS_ADDR: begin
			rdata_next[2:0] = mode_reg;
			rdata_next[cgp_pkg::STATUS_WAIT_POS] = wait_mode;
			rdata_next[cgp_pkg::STATUS_STOP_POS] = stop_mode;
		end
		default: begin
			addr_ok = 1'b0;
		end
		endcase
	end

	// answer is always one access cycle: everything is latched at setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= rd_setup;
			if (rd_setup) begin
				pslverr <= !addr_ok;
				prdata <= pwrite ? 32'h0 : rdata_next;
			end
		end
	end

	// ***************************************************************
	// pll synthesiser
	// ***************************************************************
	// the main period is measured in pclk cycles; a rational accumulator
	// then issues ticks at factor times the main rate (needs main <= pclk/4)
	logic [PERIOD_W-1:0] main_cnt_reg;
	logic [PERIOD_W-1:0] main_per_reg;
	logic [PERIOD_W+1:0] pll_acc_reg;
	logic [PERIOD_W+1:0] pll_acc_next;
	logic [PERIOD_W+1:0] pll_limit;
	logic [3:0] pll_num;
	logic pll_tick;

	always_comb begin
		case (pll_mult_reg)
		2'h0: pll_num = cgp_pkg::PLL_NUM_X2;
		2'h1: pll_num = cgp_pkg::PLL_NUM_X3;
		2'h2: pll_num = cgp_pkg::PLL_NUM_X8_3;
		default: pll_num = cgp_pkg::PLL_NUM_X4;
		endcase
	end

	assign pll_limit = {main_per_reg, 1'b0} + {2'b00, main_per_reg};
	assign pll_acc_next = pll_acc_reg + {{(PERIOD_W-2){1'b0}}, pll_num};
	assign pll_tick = pll_run_reg && !stop_mode && main_per_reg != '0 &&
		pll_acc_next >= pll_limit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_cnt_reg <= '0;
			main_per_reg <= '0;
		end else if (src_in.main_tick) begin
			main_cnt_reg <= '0;
			main_per_reg <= main_cnt_reg + 1'b1;
		end else if (main_cnt_reg != '1) begin
			main_cnt_reg <= main_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_acc_reg <= '0;
		end else if (!pll_run_reg) begin
			pll_acc_reg <= '0;
		end else if (pll_tick) begin
			pll_acc_reg <= pll_acc_next - pll_limit;
		end else if (pll_acc_next < pll_limit) begin
			pll_acc_reg <= pll_acc_next;
		end
	end

	// ***************************************************************
	// cpu clock
	// ***************************************************************
	logic [4:0] div_ratio;
	logic [4:0] act_div_reg;
	logic [4:0] cpu_cnt_reg;
	logic cpu_src_tick;
	logic cpu_tick;
	logic main_live;

	assign main_live = src_in.main_tick && !main_osc_stop_reg;

	always_comb begin
		case (cpu_div_sel_reg)
		cgp_pkg::CPU_DIV_NONE: div_ratio = 5'h01;
		5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e,
		cgp_pkg::CPU_DIV_16: div_ratio = cpu_div_sel_reg;
		default: div_ratio = cgp_pkg::CPU_DIV_RESET;
		endcase
	end

	always_comb begin
		case (mode_reg)
		cgp_pkg::CGP_PLL: cpu_src_tick = pll_tick;
		cgp_pkg::CGP_LOW_SPEED, cgp_pkg::CGP_LOW_POWER:
			cpu_src_tick = src_in.sub_tick && sub_osc_enable_reg;
		cgp_pkg::CGP_OSC, cgp_pkg::CGP_OSC_LOW_POWER:
			cpu_src_tick = src_in.osc_tick;
		default: cpu_src_tick = main_live;
		endcase
	end

	// the sub clock is never divided; other sources divide by act_div_reg
	// keyed to mode_reg, not the select bit, so a switch cycle never lets
	// one undivided fast tick through
	assign cpu_tick = cpu_src_tick && !stop_mode &&
		(mode_reg == cgp_pkg::CGP_LOW_SPEED ||
		mode_reg == cgp_pkg::CGP_LOW_POWER ||
		cpu_cnt_reg >= act_div_reg - 5'h01);

	// the new ratio is taken only at a wrap, so no short cpu period occurs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_cnt_reg <= 5'h00;
			act_div_reg <= cgp_pkg::CPU_DIV_RESET;
		end else if (cpu_tick) begin
			cpu_cnt_reg <= 5'h00;
			act_div_reg <= div_ratio;
		end else if (cpu_src_tick && !stop_mode) begin
			cpu_cnt_reg <= cpu_cnt_reg + 5'h01;
		end
	end

	// ***************************************************************
	// peripheral clocks
	// ***************************************************************
	logic periph_src_tick;
	logic periph_run;
	logic periph_tick;
	logic [2:0] div8_cnt_reg;
	logic [4:0] div32_cnt_reg;
	logic [4:0] sub32_cnt_reg;
	logic [4:0] even_cnt_reg;
	logic even_src_tick;
	logic even_tick;
	logic sub_live;

	always_comb begin
		if (osc_src_sel_reg || mode_reg == cgp_pkg::CGP_LOW_POWER) begin
			periph_src_tick = src_in.osc_tick;
		end else if (pll_src_sel_reg) begin
			periph_src_tick = pll_tick;
		end else begin
			periph_src_tick = src_in.main_tick;
		end
	end

	assign periph_run = !stop_mode && !(wait_mode && periph_stop_in_wait_reg)
		&& !(main_osc_stop_reg && !osc_src_sel_reg && !pll_src_sel_reg &&
		mode_reg != cgp_pkg::CGP_LOW_POWER);
	assign periph_tick = periph_src_tick && periph_run;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div8_cnt_reg <= 3'h0;
			div32_cnt_reg <= 5'h00;
		end else if (periph_tick) begin
			div8_cnt_reg <= div8_cnt_reg + 3'h1;
			div32_cnt_reg <= div32_cnt_reg + 5'h01;
		end
	end

	always_comb begin
		case (frac_src_sel_reg)
		cgp_pkg::FRAC_SRC_PERIPH: even_src_tick = periph_tick;
		cgp_pkg::FRAC_SRC_XIN: even_src_tick = src_in.xin_tick && !stop_mode;
		cgp_pkg::FRAC_SRC_OSC:
			even_src_tick = src_in.osc_tick && !stop_mode;
		default: even_src_tick = 1'b0;
		endcase
	end

	// divide by 2n: emit on every 2n-th source tick, n = 0 passes through
	assign even_tick = even_src_tick && (frac_div_count_reg == 4'h0 ||
		even_cnt_reg >= {frac_div_count_reg, 1'b0} - 5'h01);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			even_cnt_reg <= 5'h00;
		end else if (even_tick) begin
			even_cnt_reg <= 5'h00;
		end else if (even_src_tick) begin
			even_cnt_reg <= even_cnt_reg + 5'h01;
		end
	end

	// sub clock divider ignores wait and the peripheral stop bit
	assign sub_live = src_in.sub_tick && sub_osc_enable_reg && !stop_mode;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sub32_cnt_reg <= 5'h00;
		end else if (sub_live) begin
			sub32_cnt_reg <= sub32_cnt_reg + 5'h01;
		end
	end

	// ***************************************************************
	// registered clock outputs and pins
	// ***************************************************************
	logic cpu_run;
	logic pin_next;
	logic sub_out;
	logic div8_out;
	logic div32_out;

	assign cpu_run = cpu_tick && !wait_mode;
	assign sub_out = sub_live;
	assign div8_out = periph_tick && div8_cnt_reg == cgp_pkg::PERIPH_DIV8_LAST;
	assign div32_out = periph_tick &&
		div32_cnt_reg == cgp_pkg::PERIPH_DIV32_LAST;

	always_comb begin
		case (clk_out_pin_sel_reg)
		cgp_pkg::CLK_OUT_PIN_SUB: pin_next = sub_out;
		cgp_pkg::CLK_OUT_PIN_DIV8: pin_next = div8_out;
		cgp_pkg::CLK_OUT_PIN_DIV32: pin_next = div32_out;
		default: begin
			if (!micro_mode) begin
				pin_next = 1'b0;
			end else if (ale_pin_sel_reg == cgp_pkg::ALE_ALE) begin
				pin_next = ale_in;
			end else if (ale_pin_sel_reg == cgp_pkg::ALE_BUSCLK &&
				!busclk_out_disable_reg) begin
				pin_next = cpu_run;
			end else begin
				pin_next = 1'b0;
			end
		end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_out <= '0;
			clk_out_pin <= 1'b0;
			bus_clk_pin <= 1'b0;
		end else begin
			clk_out.pll_clk <= pll_tick;
			clk_out.cpu_clk <= cpu_run;
			clk_out.bus_clk <= cpu_run;
			clk_out.wdt_clk <= wdt_osc_sel_reg ? src_in.osc_tick :
				cpu_run;
			clk_out.periph_div1 <= periph_tick;
			clk_out.periph_div8 <= div8_out;
			clk_out.periph_div32 <= div32_out;
			clk_out.adc_clk <= periph_tick;
			clk_out.even_div_clk <= even_tick;
			clk_out.sub_div32_clk <= sub_live &&
				sub32_cnt_reg == cgp_pkg::PERIPH_DIV32_LAST;
			clk_out_pin <= pin_next;
			bus_clk_pin <= micro_mode && cpu_run;
		end
	end

endmodule
`default_nettype wire

/* File: tb/cgp_src_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cgp_src_model #(
	parameter int MAIN_P = 4,
	parameter int XIN_P = 5,
	parameter int SUB_P = 6,
	parameter int OSC_P = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sub_on,
	output cgp_pkg::cgp_src_type src_in
);
	int cm, cx, cs, co;
	// ****************************************
	// oscillator ticks, one per source period
	// ****************************************
	// main spacing of 4 or more lets the pll reach x4
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cm <= 0;
			cx <= 0;
			cs <= 0;
			co <= 0;
			src_in <= '0;
		end else begin
			cm <= (cm + 1) % MAIN_P;
			cx <= (cx + 1) % XIN_P;
			cs <= (cs + 1) % SUB_P;
			co <= (co + 1) % OSC_P;
			src_in.main_tick <= (cm == 0);
			src_in.xin_tick <= (cx == 0);
			// a crystal that is not enabled gives no ticks at all
			src_in.sub_tick <= sub_on && (cs == 0);
			src_in.osc_tick <= (co == 0);
		end
	end
endmodule
`default_nettype wire

/* File: tb/cgp_clock_gen_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module cgp_clock_gen_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire cgp_pkg::cgp_src_type src_in,
	input wire logic micro_mode,
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire cgp_pkg::cgp_clk_type clk_out,
	input wire logic bus_clk_pin
);
	// ****************************************
	// clock relations
	// ****************************************
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_bus_eq_cpu: assert property (
		clk_out.bus_clk == clk_out.cpu_clk) else $error("bus clk off");
	a_bus_pin_mode: assert property (
		bus_clk_pin |-> micro_mode || $past(micro_mode))
		else $error("bus pin outside micro mode");
	a_cpu_wait_gate: assert property (
		wait_mode && $past(wait_mode) |-> !clk_out.cpu_clk)
		else $error("cpu tick in wait");
	a_stop_gate: assert property (
		stop_mode && $past(stop_mode) |->
		!(clk_out.cpu_clk || clk_out.periph_div1))
		else $error("tick in stop");
	a_div8_gap: assert property (
		clk_out.periph_div8 |=> !clk_out.periph_div8 [*7])
		else $error("div8 too fast");
	a_div32_on_div8: assert property (
		clk_out.periph_div32 |-> clk_out.periph_div8)
		else $error("div32 off div8");
	a_adc_follow: assert property (
		clk_out.adc_clk == clk_out.periph_div1)
		else $error("adc clk off");
	a_sub32_cause: assert property (
		clk_out.sub_div32_clk |-> $past(src_in.sub_tick))
		else $error("sub div32 without sub tick");
endmodule
bind cgp_clock_gen cgp_clock_gen_chk u_chk (
	.pclk(pclk),
	.presetn(presetn),
	.src_in(src_in),
	.micro_mode(micro_mode),
	.wait_mode(wait_mode),
	.stop_mode(stop_mode),
	.clk_out(clk_out),
	.bus_clk_pin(bus_clk_pin)
);
`default_nettype wire

/* File: tb/test_clock_gen_select_power_modes.sv */
`timescale 1ns/1ns
`default_nettype none
module test_clock_gen_select_power_modes;
	logic pclk, presetn, psel, penable, pwrite, micro_mode, wait_mode, er;
	logic stop_mode, ale_in, pready, pslverr, clk_out_pin, bus_clk_pin, sub_on;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] s;
	cgp_pkg::cgp_src_type src_in;
	cgp_pkg::cgp_clk_type clk_out;
	int bad_count, n_compared, g, c4, c5, c6;
	assign s = {bus_clk_pin, clk_out.even_div_clk, clk_out_pin,
		clk_out.sub_div32_clk, clk_out.periph_div1, clk_out.periph_div32,
		clk_out.periph_div8, clk_out.cpu_clk};
	cgp_src_model u_src (.pclk(pclk), .presetn(presetn), .sub_on(sub_on),
		.src_in(src_in));
	cgp_clock_gen u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .src_in(src_in),
		.micro_mode(micro_mode), .wait_mode(wait_mode), .stop_mode(stop_mode),
		.ale_in(ale_in), .clk_out(clk_out), .clk_out_pin(clk_out_pin),
		.bus_clk_pin(bus_clk_pin));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic hang();
		bad_count++;
		conclude();
	endtask
	// an idle cycle follows each transfer so psel never changes twice at once
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) hang();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// third tick apart: the first two absorb a pending divider change
	task automatic gap(input int k);
		repeat (3) begin
			g = 0;
			do begin
				@(posedge pclk);
				g++;
			end while (s[k] !== 1'b1 && g < 3000);
		end
		if (g >= 3000) hang();
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		apb(1'b0, 8'h08, 32'h0);
		check(rd, 32'h8);
		gap(0);
		check(g, 32'h20);
		apb(1'b0, 8'h1c, 32'h0);
		check(er, 32'h1);
		$display("t_reset done");
	endtask
	task automatic t_div();
		logic [4:0] c [9] = '{5'h12, 5'h02, 5'h03, 5'h04, 5'h06, 5'h0a,
			5'h0c, 5'h0e, 5'h10};
		foreach (c[i]) begin
			apb(1'b1, 8'h08, 32'(c[i]));
			gap(0);
			check(g, 32'(4 * (c[i] == 5'h12 ? 1 : int'(c[i]))));
		end
		apb(1'b1, 8'h08, 32'h8);
		$display("t_div done");
	endtask
	task automatic t_pll();
		logic [1:0] mc [3] = '{2'h0, 2'h2, 2'h3};
		logic [3:0] nm [3] = '{cgp_pkg::PLL_NUM_X2, cgp_pkg::PLL_NUM_X8_3,
			cgp_pkg::PLL_NUM_X4};
		apb(1'b1, 8'h14, 32'h3);
		apb(1'b1, 8'h00, 32'h100);
		foreach (mc[i]) begin
			apb(1'b1, 8'h04, 32'h80 | 32'(mc[i]));
			gap(1);
			check(g, 32'(96 / nm[i]));
		end
		apb(1'b0, 8'h18, 32'h0);
		check(rd[2:0], cgp_pkg::CGP_PLL);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h04, 32'h0);
		$display("t_pll done");
	endtask
	task automatic t_out();
		sub_on <= 1'b1;
		apb(1'b1, 8'h10, 32'h2);
		apb(1'b1, 8'h00, 32'h12);
		gap(6);
		check(g, 32'h10);
		gap(5);
		check(g, 32'h20);
		gap(4);
		check(g, 32'hc0);
		apb(1'b1, 8'h00, 32'h13);
		gap(5);
		check(g, 32'h80);
		apb(1'b1, 8'h00, 32'h11);
		gap(5);
		check(g, 32'h6);
		apb(1'b1, 8'h00, 32'h10);
		gap(5);
		check(g, 32'h20);
		gap(7);
		check(g, 32'h20);
		apb(1'b1, 8'h0c, 32'h1);
		ale_in <= 1'b1;
		repeat (3) @(posedge pclk);
		check(clk_out_pin, 1'b1);
		// leaving microprocessor mode must silence both pins
		micro_mode <= 1'b0;
		@(posedge pclk);
		c4 = 0;
		repeat (64) begin
			@(posedge pclk);
			c4 += s[7];
		end
		check(c4, 32'h0);
		check(clk_out_pin, 1'b0);
		micro_mode <= 1'b1;
		$display("t_out done");
	endtask
	task automatic t_wait();
		apb(1'b1, 8'h0c, 32'h10);
		apb(1'b1, 8'h00, 32'h14);
		wait_mode <= 1'b1;
		repeat (3) @(posedge pclk);
		c4 = 0;
		c5 = 0;
		c6 = 0;
		repeat (400) begin
			@(posedge pclk);
			c4 += s[3];
			c5 += s[4];
			c6 += s[6];
		end
		check(c4, 32'h0);
		check(c5 > 0, 1'b1);
		check(c6 > 0, 1'b1);
		wait_mode <= 1'b0;
		@(posedge pclk);
		$display("t_wait done");
	endtask
	task automatic t_stop();
		apb(1'b1, 8'h08, 32'h2);
		stop_mode <= 1'b1;
		repeat (3) @(posedge pclk);
		stop_mode <= 1'b0;
		@(posedge pclk);
		apb(1'b0, 8'h08, 32'h0);
		check(rd, 32'h8);
		$display("t_stop done");
	endtask
	// oscillator low-power keeps the divider, so software sets div 8 itself
	task automatic t_osc();
		apb(1'b1, 8'h00, 32'h200);
		apb(1'b1, 8'h08, 32'h2);
		gap(0);
		check(g, 32'h6);
		apb(1'b1, 8'h00, 32'h220);
		apb(1'b0, 8'h18, 32'h0);
		check(rd[2:0], cgp_pkg::CGP_OSC_LOW_POWER);
		gap(0);
		check(g, 32'h6);
		apb(1'b1, 8'h08, 32'h8);
		apb(1'b1, 8'h00, 32'h0);
		gap(0);
		check(g, 32'h20);
		$display("t_osc done");
	endtask
	task automatic t_low();
		apb(1'b1, 8'h00, 32'h90);
		gap(0);
		check(g, 32'h6);
		gap(1);
		check(g, 32'h20);
		apb(1'b1, 8'h08, 32'h2);
		apb(1'b1, 8'h00, 32'hb0);
		apb(1'b0, 8'h08, 32'h0);
		check(rd, 32'h8);
		apb(1'b0, 8'h18, 32'h0);
		check(rd[2:0], cgp_pkg::CGP_LOW_POWER);
		gap(1);
		check(g, 32'h18);
		apb(1'b1, 8'h00, 32'h10);
		$display("t_low done");
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		micro_mode = 1'b1;
		wait_mode = 1'b0;
		stop_mode = 1'b0;
		ale_in = 1'b0;
		sub_on = 1'b0;
		bad_count = 0;
		n_compared = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_div();
		t_pll();
		t_out();
		t_wait();
		t_stop();
		t_osc();
		t_low();
		conclude();
	end
endmodule
`default_nettype wire
